// ===== rtl/tqhp_top.sv
// Transmit queue host path: registers, frame buffer and enqueue control
// Function
// - Control word bit 15 requests transmit interrupt after frame completes; 14:6 reserved.
// - Control word bits 5:0 are frame id reported in transmit status.
// - Byte count bits 10:0 give frame length and size the buffer allocation.
// - Addresses leave exactly as host wrote them; no own source address.
// - Length or type word passes through as plain payload.
// - Transmit control bits 3..0: flow control, padding, CRC, transmit enable.
// - Transmit control bits 8:5 enable ICMP, UDP, TCP, IP checksums.
// - Free transmit buffer bytes read in a 13-bit field.
// - Queue command bit 0 enqueues prepared frame; clears when frame completes.
// - Queue command bit 1 raises status bit 6 when requested space free.
// - Receive queue command bit 3 opens data register access to buffer.
// - Data pointer bit 14 makes pointer advance on each data access.
// - Enable bit 14 gates transmit done, bit 6 gates space available.
// - Writing ones to interrupt status clears those bits.
// - Transmit status shows the last frame given to the MAC: its id, and its MAC result once it completes.
`timescale 1ns/100ps
module tqhp_top
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Host register port
	input wire logic [tqhp_pkg::TQHP_ADDR_W-1:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	// Host data register
	input wire logic data_wr,
	input wire logic [15:0] data_wdata,
	// MAC transmit stream
	output tqhp_pkg::tqhp_byte_s mac_byte,
	output logic mac_valid,
	input wire logic mac_ready,
	input wire logic mac_done,
	input wire logic [1:0] mac_status,
	output tqhp_pkg::tqhp_mac_cfg_s mac_cfg,
	// Interrupt
	output logic irq_n
);
	import tqhp_pkg::*;

	logic [15:0] mem [0:3071];
	logic [15:0] tx_control_reg, tx_control_next;
	logic [15:0] tx_status_reg, tx_status_next;
	logic [1:0] tq_cmd_reg, tq_cmd_next;
	logic dma_open_reg, dma_open_next;
	logic [15:0] data_ptr_reg, data_ptr_next;
	logic [15:0] int_enable_reg, int_enable_next;
	logic [15:0] int_status_reg, int_status_next;
	logic [15:0] space_req_reg, space_req_next;
	logic [12:0] used_reg, used_next;
	logic [12:0] pend_reg, pend_next;
	logic [11:0] prep_base_reg, prep_base_next;
	logic [11:0] tx_base_reg, tx_base_next;
	logic busy_reg, busy_next;
	logic start_reg, start_next;
	logic [15:0] rdata_reg, rdata_next;
	logic irq_n_reg, irq_n_next;
	tqhp_mac_cfg_s cfg_reg, cfg_next;
	logic [11:0] eng_raddr;
	logic [5:0] eng_id;
	logic eng_done;
	logic eng_irq;
	logic [12:0] free_bytes;
	logic [10:0] new_count;
	logic [12:0] alloc_bytes;
	logic [17:0] need_bytes;
	logic wr_hit;
	logic [11:0] data_waddr;

	tqhp_tx_engine u_engine
	(
		.clock(clock),
		.reset(reset),
		.start(start_reg),
		.base(tx_base_reg),
		.mem_raddr(eng_raddr),
		.mem_rdata(mem[eng_raddr]),
		.mac_byte(mac_byte),
		.mac_valid(mac_valid),
		.mac_ready(mac_ready),
		.mac_done(mac_done),
		.frame_id(eng_id),
		.done(eng_done),
		.done_irq(eng_irq)
	);

	// Buffer space bookkeeping
	always_comb
	begin
		free_bytes = TQHP_BUF_BYTES - used_reg;
		new_count = mem[tqhp_wrap_add(prep_base_reg, 12'h001)][TQHP_BC_MSB:0];
		alloc_bytes = TQHP_HDR_BYTES + {({2'b00, new_count} + 13'h0003) & 13'h1FFC};
		need_bytes = {space_req_reg, 2'b00};
		data_waddr = tqhp_wrap_add(prep_base_reg, {2'b00, data_ptr_reg[TQHP_DP_PTR_MSB:1]});
	end

	// Register writes, queue control and status
	always_comb
	begin
		tx_control_next = tx_control_reg;
		tx_status_next = tx_status_reg;
		tq_cmd_next = tq_cmd_reg;
		dma_open_next = dma_open_reg;
		data_ptr_next = data_ptr_reg;
		int_enable_next = int_enable_reg;
		int_status_next = int_status_reg;
		space_req_next = space_req_reg;
		used_next = used_reg;
		pend_next = pend_reg;
		prep_base_next = prep_base_reg;
		tx_base_next = tx_base_reg;
		busy_next = busy_reg;
		start_next = 1'b0;
		wr_hit = 1'b0;
		// Host register writes
		if (host_wr)
		begin
			unique case (host_addr)
				TQHP_OFS_TX_CONTROL: tx_control_next = host_wdata & TQHP_TC_MASK;
				TQHP_OFS_TX_QUEUE_COMMAND:
				begin
					if (host_wdata[TQHP_TQ_ENQ_BIT] && !tq_cmd_reg[TQHP_TQ_ENQ_BIT])
					begin
						// Commit the prepared frame and reserve its space
						tq_cmd_next[TQHP_TQ_ENQ_BIT] = 1'b1;
						tx_base_next = prep_base_reg;
						prep_base_next = tqhp_wrap_add(prep_base_reg, alloc_bytes[12:1]);
						used_next = used_reg + alloc_bytes;
						pend_next = alloc_bytes;
					end
					if (host_wdata[TQHP_TQ_SPACE_BIT])
					begin
						tq_cmd_next[TQHP_TQ_SPACE_BIT] = 1'b1;
					end
				end
				TQHP_OFS_RX_QUEUE_COMMAND: dma_open_next = host_wdata[TQHP_RQ_DMA_BIT];
				TQHP_OFS_TX_DATA_POINTER: data_ptr_next = host_wdata & TQHP_DP_MASK;
				TQHP_OFS_INT_ENABLE: int_enable_next = host_wdata & TQHP_IRQ_MASK;
				TQHP_OFS_INT_STATUS: int_status_next = int_status_reg & ~host_wdata;
				TQHP_OFS_TX_SPACE_REQUEST: space_req_next = host_wdata;
				default: wr_hit = 1'b0;
			endcase
		end
		// Data register access
		if (data_wr && dma_open_reg)
		begin
			wr_hit = 1'b1;
			if (data_ptr_reg[TQHP_DP_AUTO_BIT])
			begin
				data_ptr_next[TQHP_DP_PTR_MSB:0] = data_ptr_reg[TQHP_DP_PTR_MSB:0] + TQHP_PTR_STEP;
			end
		end
		// Launch the engine once transmit is enabled
		if (tq_cmd_reg[TQHP_TQ_ENQ_BIT] && !busy_reg && tx_control_reg[TQHP_TC_EN_BIT])
		begin
			busy_next = 1'b1;
			start_next = 1'b1;
		end
		if (start_reg)
		begin
			tx_status_next = TQHP_ZERO16;
		end
		if (eng_done)
		begin
			// Frame finished: release space, report, drop enqueue bit
			busy_next = 1'b0;
			tq_cmd_next[TQHP_TQ_ENQ_BIT] = 1'b0;
			used_next = used_next - pend_reg;
			tx_status_next[TQHP_ST_MAC_LSB+1:TQHP_ST_MAC_LSB] = mac_status_hold(mac_status);
			if (eng_irq)
			begin
				int_status_next[TQHP_IS_TXDONE_BIT] = 1'b1;
			end
		end
		// Identifier of the frame in flight
		if (busy_reg)
		begin
			tx_status_next[TQHP_CW_ID_MSB:0] = eng_id;
		end
		// Space available check
		if (tq_cmd_reg[TQHP_TQ_SPACE_BIT] && ({5'h00, free_bytes} >= need_bytes))
		begin
			int_status_next[TQHP_IS_SPACE_BIT] = 1'b1;
			tq_cmd_next[TQHP_TQ_SPACE_BIT] = 1'b0;
		end
	end

	// MAC result bits as reported in status
	function automatic logic [1:0] mac_status_hold(input logic [1:0] s);
		return s;
	endfunction : mac_status_hold

	// Read data, configuration and interrupt output
	always_comb
	begin
		rdata_next = rdata_reg;
		if (host_rd)
		begin
			unique case (host_addr)
				TQHP_OFS_TX_CONTROL: rdata_next = tx_control_reg;
				TQHP_OFS_TX_STATUS: rdata_next = tx_status_reg;
				TQHP_OFS_TX_FREE_MEMORY: rdata_next = {3'b000, free_bytes};
				TQHP_OFS_TX_QUEUE_COMMAND: rdata_next = {14'h0000, tq_cmd_reg};
				TQHP_OFS_RX_QUEUE_COMMAND: rdata_next = {12'h000, dma_open_reg, 3'b000};
				TQHP_OFS_TX_DATA_POINTER: rdata_next = data_ptr_reg;
				TQHP_OFS_INT_ENABLE: rdata_next = int_enable_reg;
				TQHP_OFS_INT_STATUS: rdata_next = int_status_reg;
				TQHP_OFS_TX_SPACE_REQUEST: rdata_next = space_req_reg;
				default: rdata_next = TQHP_ZERO16;
			endcase
		end
		cfg_next.flow_control = tx_control_reg[TQHP_TC_FLOW_BIT];
		cfg_next.pad_short = tx_control_reg[TQHP_TC_PAD_BIT];
		cfg_next.crc_append = tx_control_reg[TQHP_TC_CRC_BIT];
		cfg_next.enable = tx_control_reg[TQHP_TC_EN_BIT];
		cfg_next.csum_icmp = tx_control_reg[TQHP_TC_ICMP_BIT];
		cfg_next.csum_udp = tx_control_reg[TQHP_TC_UDP_BIT];
		cfg_next.csum_tcp = tx_control_reg[TQHP_TC_TCP_BIT];
		cfg_next.csum_ip = tx_control_reg[TQHP_TC_IP_BIT];
		irq_n_next = ~|(int_status_reg & int_enable_reg);
	end

	// Frame buffer storage, written through the data register
	always_ff @(posedge clock)
	begin
		if (wr_hit)
		begin
			mem[data_waddr] <= data_wdata;
		end
	end

	// Register, queue and status group
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			tx_control_reg <= TQHP_ZERO16;
			tx_status_reg <= TQHP_ZERO16;
			tq_cmd_reg <= 2'b00;
			dma_open_reg <= 1'b0;
			data_ptr_reg <= TQHP_ZERO16;
			int_enable_reg <= TQHP_ZERO16;
			int_status_reg <= TQHP_ZERO16;
			space_req_reg <= TQHP_ZERO16;
			used_reg <= 13'h0000;
			pend_reg <= 13'h0000;
			prep_base_reg <= 12'h000;
			tx_base_reg <= 12'h000;
			busy_reg <= 1'b0;
			start_reg <= 1'b0;
		end
		else
		begin
			tx_control_reg <= tx_control_next;
			tx_status_reg <= tx_status_next;
			tq_cmd_reg <= tq_cmd_next;
			dma_open_reg <= dma_open_next;
			data_ptr_reg <= data_ptr_next;
			int_enable_reg <= int_enable_next;
			int_status_reg <= int_status_next;
			space_req_reg <= space_req_next;
			used_reg <= used_next;
			pend_reg <= pend_next;
			prep_base_reg <= prep_base_next;
			tx_base_reg <= tx_base_next;
			busy_reg <= busy_next;
			start_reg <= start_next;
		end
	end

	// Read data, configuration and interrupt registers
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			rdata_reg <= TQHP_ZERO16;
			irq_n_reg <= 1'b1;
			cfg_reg <= '0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			irq_n_reg <= irq_n_next;
			cfg_reg <= cfg_next;
		end
	end

	assign host_rdata = rdata_reg;
	assign mac_cfg = cfg_reg;
	assign irq_n = irq_n_reg;
endmodule : tqhp_top

// ===== rtl/tqhp_pkg.sv
// Shared constants, carriers and helpers for the transmit queue host path
package tqhp_pkg;
	localparam int TQHP_ADDR_W = 9;
	localparam int TQHP_WA_W = 12;
	localparam logic [12:0] TQHP_BUF_BYTES = 13'h1800;
	localparam logic [12:0] TQHP_BUF_WORDS = 13'h0C00;
	// Register offsets
	localparam logic [8:0] TQHP_OFS_TX_CONTROL = 9'h170;
	localparam logic [8:0] TQHP_OFS_TX_STATUS = 9'h172;
	localparam logic [8:0] TQHP_OFS_TX_FREE_MEMORY = 9'h178;
	localparam logic [8:0] TQHP_OFS_TX_QUEUE_COMMAND = 9'h180;
	localparam logic [8:0] TQHP_OFS_RX_QUEUE_COMMAND = 9'h182;
	localparam logic [8:0] TQHP_OFS_TX_DATA_POINTER = 9'h184;
	localparam logic [8:0] TQHP_OFS_INT_ENABLE = 9'h190;
	localparam logic [8:0] TQHP_OFS_INT_STATUS = 9'h192;
	localparam logic [8:0] TQHP_OFS_TX_SPACE_REQUEST = 9'h19E;
	// Field positions
	localparam int TQHP_CW_IRQ_BIT = 15;
	localparam int TQHP_CW_ID_MSB = 5;
	localparam int TQHP_BC_MSB = 10;
	localparam int TQHP_TC_FLOW_BIT = 3;
	localparam int TQHP_TC_PAD_BIT = 2;
	localparam int TQHP_TC_CRC_BIT = 1;
	localparam int TQHP_TC_EN_BIT = 0;
	localparam int TQHP_TC_ICMP_BIT = 8;
	localparam int TQHP_TC_UDP_BIT = 7;
	localparam int TQHP_TC_TCP_BIT = 6;
	localparam int TQHP_TC_IP_BIT = 5;
	localparam int TQHP_TQ_ENQ_BIT = 0;
	localparam int TQHP_TQ_SPACE_BIT = 1;
	localparam int TQHP_RQ_DMA_BIT = 3;
	localparam int TQHP_DP_AUTO_BIT = 14;
	localparam int TQHP_DP_PTR_MSB = 10;
	localparam int TQHP_IS_TXDONE_BIT = 14;
	localparam int TQHP_IS_SPACE_BIT = 6;
	localparam int TQHP_ST_MAC_LSB = 12;
	// Writable masks, reset value, header sizes and pointer step
	localparam logic [15:0] TQHP_TC_MASK = 16'h01EF;
	localparam logic [15:0] TQHP_IRQ_MASK = 16'h4040;
	localparam logic [15:0] TQHP_DP_MASK = 16'h47FF;
	localparam logic [15:0] TQHP_ZERO16 = 16'h0000;
	localparam logic [12:0] TQHP_HDR_BYTES = 13'h0004;
	localparam logic [11:0] TQHP_HDR_WORDS = 12'h002;
	localparam logic [10:0] TQHP_PTR_STEP = 11'h002;

	typedef struct packed {
		logic flow_control;
		logic pad_short;
		logic crc_append;
		logic enable;
		logic csum_icmp;
		logic csum_udp;
		logic csum_tcp;
		logic csum_ip;
	} tqhp_mac_cfg_s;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} tqhp_byte_s;

	// Word address advance with wrap around the buffer
	function automatic logic [11:0] tqhp_wrap_add(input logic [11:0] a, input logic [11:0] n);
		logic [12:0] s;
		s = {1'b0, a} + {1'b0, n};
		if (s >= TQHP_BUF_WORDS)
		begin
			s = s - TQHP_BUF_WORDS;
		end
		return s[11:0];
	endfunction : tqhp_wrap_add
endpackage : tqhp_pkg

// ===== rtl/tqhp_tx_engine.sv
// Reads one queued frame from the buffer and streams it to the MAC
`timescale 1ns/100ps
module tqhp_tx_engine
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic [11:0] base,
	// Buffer read
	output logic [11:0] mem_raddr,
	input wire logic [15:0] mem_rdata,
	// MAC stream
	output tqhp_pkg::tqhp_byte_s mac_byte,
	output logic mac_valid,
	input wire logic mac_ready,
	input wire logic mac_done,
	// Completion
	output logic [5:0] frame_id,
	output logic done,
	output logic done_irq
);
	import tqhp_pkg::*;

	typedef enum logic [2:0] {
		TQHP_IDLE = 3'b000,
		TQHP_CTRL = 3'b001,
		TQHP_COUNT = 3'b011,
		TQHP_DATA = 3'b010,
		TQHP_WAIT = 3'b110
	} tqhp_state_e;

	tqhp_state_e state_reg, state_next;
	logic [10:0] count_reg, count_next;
	logic [10:0] idx_reg, idx_next;
	logic irq_reg, irq_next;
	logic [5:0] id_reg, id_next;
	tqhp_byte_s byte_reg, byte_next;
	logic valid_reg, valid_next;
	logic done_reg, done_next;
	logic [11:0] raddr;

	always_comb
	begin
		state_next = state_reg;
		count_next = count_reg;
		idx_next = idx_reg;
		irq_next = irq_reg;
		id_next = id_reg;
		byte_next = byte_reg;
		valid_next = valid_reg;
		done_next = 1'b0;
		raddr = tqhp_wrap_add(base, {2'b00, idx_reg[10:1]} + TQHP_HDR_WORDS);
		unique case (state_reg)
			TQHP_IDLE:
			begin
				if (start)
				begin
					state_next = TQHP_CTRL;
				end
			end
			TQHP_CTRL:
			begin
				raddr = base;
				irq_next = mem_rdata[TQHP_CW_IRQ_BIT];
				id_next = mem_rdata[TQHP_CW_ID_MSB:0];
				state_next = TQHP_COUNT;
			end
			TQHP_COUNT:
			begin
				raddr = tqhp_wrap_add(base, 12'h001);
				count_next = mem_rdata[TQHP_BC_MSB:0];
				idx_next = 11'h000;
				state_next = TQHP_DATA;
			end
			TQHP_DATA:
			begin
				if (!valid_reg || mac_ready)
				begin
					if (idx_reg < count_reg)
					begin
						// Bytes go out untouched, addresses and type word included
						byte_next.data = idx_reg[0] ? mem_rdata[15:8] : mem_rdata[7:0];
						byte_next.last = (idx_reg == count_reg - 11'h001);
						valid_next = 1'b1;
						idx_next = idx_reg + 11'h001;
					end
					else
					begin
						valid_next = 1'b0;
						state_next = TQHP_WAIT;
					end
				end
			end
			TQHP_WAIT:
			begin
				if (mac_done)
				begin
					done_next = 1'b1;
					state_next = TQHP_IDLE;
				end
			end
			default:
			begin
				state_next = TQHP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= TQHP_IDLE;
			count_reg <= 11'h000;
			idx_reg <= 11'h000;
			irq_reg <= 1'b0;
			id_reg <= 6'h00;
			byte_reg <= '0;
			valid_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			count_reg <= count_next;
			idx_reg <= idx_next;
			irq_reg <= irq_next;
			id_reg <= id_next;
			byte_reg <= byte_next;
			valid_reg <= valid_next;
			done_reg <= done_next;
		end
	end

	assign mem_raddr = raddr;
	assign mac_byte = byte_reg;
	assign mac_valid = valid_reg;
	assign frame_id = id_reg;
	assign done = done_reg;
	assign done_irq = irq_reg;
endmodule : tqhp_tx_engine

// ===== test/tqhp_top_sva.sv
// Checker for the transmit queue host path ports
`timescale 1ns/100ps
module tqhp_checker
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Host side
	input wire logic [tqhp_pkg::TQHP_ADDR_W-1:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata,
	input wire logic data_wr,
	input wire logic [15:0] data_wdata,
	// MAC side
	input wire tqhp_pkg::tqhp_byte_s mac_byte,
	input wire logic mac_valid,
	input wire logic mac_ready,
	input wire logic mac_done,
	input wire logic [1:0] mac_status,
	input wire tqhp_pkg::tqhp_mac_cfg_s mac_cfg,
	input wire logic irq_n
);
	import tqhp_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	AST_CFG_EN: assert property (host_wr && host_addr == TQHP_OFS_TX_CONTROL |-> ##2
		mac_cfg.enable == $past(host_wdata[TQHP_TC_EN_BIT], 2)) else $error("enable copy wrong");
	AST_CFG_CSUM: assert property (host_wr && host_addr == TQHP_OFS_TX_CONTROL |-> ##2
		{mac_cfg.csum_icmp, mac_cfg.csum_udp, mac_cfg.csum_tcp, mac_cfg.csum_ip}
		== $past(host_wdata[8:5], 2)) else $error("checksum copy wrong");
	AST_BYTE_HOLD: assert property (mac_valid && !mac_ready |=>
		mac_valid && $stable(mac_byte)) else $error("byte changed before accept");
	AST_LAST_DROP: assert property (mac_valid && mac_ready && mac_byte.last |=>
		!mac_valid) else $error("valid after last byte");
	AST_FREE_RANGE: assert property (host_rd && host_addr == TQHP_OFS_TX_FREE_MEMORY |=>
		host_rdata <= 16'h1800) else $error("free space out of range");
	AST_TC_RSVD: assert property (host_rd && host_addr == TQHP_OFS_TX_CONTROL |=>
		(host_rdata & ~TQHP_TC_MASK) == 16'h0000) else $error("control reserved bits set");
	AST_IS_RSVD: assert property (host_rd && host_addr == TQHP_OFS_INT_STATUS |=>
		(host_rdata & ~TQHP_IRQ_MASK) == 16'h0000) else $error("status reserved bits set");
	AST_IRQ_MASK: assert property (host_wr && host_addr == TQHP_OFS_INT_ENABLE
		&& host_wdata == 16'h0000 ##1 !(host_wr && host_addr == TQHP_OFS_INT_ENABLE) |=> irq_n)
		else $error("interrupt not masked");
	COV_LAST: cover property (mac_valid && mac_ready && mac_byte.last);
	COV_STALL: cover property (mac_valid && !mac_ready);
	COV_IRQ: cover property (!irq_n);
endmodule : tqhp_checker

// ===== test/tqhp_mac_model.sv
// MAC sink model that records bytes and reports frame end
`timescale 1ns/100ps
module tqhp_mac_model
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Stream
	input wire tqhp_pkg::tqhp_byte_s mac_byte,
	input wire logic mac_valid,
	output logic mac_ready,
	output logic mac_done,
	// Control
	input wire logic stall
);
	import tqhp_pkg::*;
	logic tog;
	logic [7:0] got [0:4095];
	int n;
	int nl;
	// Slow mode accepts on every other cycle
	assign mac_ready = !stall || tog;
	always @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			tog <= 1'b0;
			mac_done <= 1'b0;
			n <= 0;
			nl <= 0;
		end
		else
		begin
			tog <= !tog;
			mac_done <= mac_valid && mac_ready && mac_byte.last;
			if (mac_valid && mac_ready)
			begin
				got[n] <= mac_byte.data;
				n <= n + 1;
				if (mac_byte.last)
				begin
					nl <= n + 1;
				end
			end
		end
	end
endmodule : tqhp_mac_model

// ===== test/test_transmit_queue_host_path.sv
// Testbench for the transmit queue host path
`timescale 1ns/100ps
module test_transmit_queue_host_path;
	import tqhp_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [8:0] host_addr = 9'h000;
	logic host_rd = 1'b0;
	logic host_wr = 1'b0;
	logic data_wr = 1'b0;
	logic stall = 1'b0;
	logic [15:0] host_wdata = 16'h0000;
	logic [15:0] data_wdata = 16'h0000;
	logic [15:0] host_rdata;
	logic [15:0] rdv;
	logic [1:0] mac_status = 2'b10;
	tqhp_byte_s mac_byte;
	tqhp_mac_cfg_s mac_cfg;
	logic mac_valid;
	logic mac_ready;
	logic mac_done;
	logic irq_n;
	int n_errors = 0;
	int compares = 0;
	always #2 clock = !clock;
	tqhp_top dut (.clock(clock), .reset(reset), .host_addr(host_addr), .host_rd(host_rd),
		.host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata), .data_wr(data_wr),
		.data_wdata(data_wdata), .mac_byte(mac_byte), .mac_valid(mac_valid),
		.mac_ready(mac_ready), .mac_done(mac_done), .mac_status(mac_status),
		.mac_cfg(mac_cfg), .irq_n(irq_n));
	tqhp_mac_model mac (.clock(clock), .reset(reset), .mac_byte(mac_byte),
		.mac_valid(mac_valid), .mac_ready(mac_ready), .mac_done(mac_done), .stall(stall));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge clock);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge clock);
		host_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [8:0] a);
		@(posedge clock);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge clock);
		host_rd <= 1'b0;
		#1;
		rdv = host_rdata;
	endtask : rd
	task automatic dw(input logic [15:0] d);
		@(posedge clock);
		data_wdata <= d;
		data_wr <= 1'b1;
		@(posedge clock);
		data_wr <= 1'b0;
	endtask : dw
	function automatic logic [7:0] pb(input int k, input logic [5:0] id);
		return 8'(k * 3) ^ {2'b00, id};
	endfunction : pb
	task automatic t_reset();
		rd(TQHP_OFS_TX_FREE_MEMORY);
		chk("free", 16'h1800, rdv);
		rd(TQHP_OFS_INT_STATUS);
		chk("status", 16'h0000, rdv);
		rd(9'h100);
		chk("unmapped", 16'h0000, rdv);
		chk("irq_n", 16'h0001, {15'h0000, irq_n});
	endtask : t_reset
	task automatic t_control();
		wr(TQHP_OFS_TX_CONTROL, 16'hFFFF);
		rd(TQHP_OFS_TX_CONTROL);
		chk("control", 16'h01EF, rdv);
		chk("cfg", 16'h00FF, {8'h00, mac_cfg});
		wr(TQHP_OFS_TX_CONTROL, 16'h0021);
		@(posedge clock);
		#1;
		chk("cfg", 16'h0011, {8'h00, mac_cfg});
	endtask : t_control
	task automatic t_frame(input logic [5:0] id, input int cnt, input logic irq, input logic slow);
		int nw;
		int n0;
		int k;
		nw = ((cnt + 3) / 4) * 2;
		n0 = mac.n;
		stall <= slow;
		mac_status <= {slow, !slow};
		wr(TQHP_OFS_RX_QUEUE_COMMAND, 16'h0008);
		wr(TQHP_OFS_TX_DATA_POINTER, 16'h4000);
		dw({irq, 9'h000, id});
		dw(16'(cnt));
		for (k = 0; k < nw; k++)
			dw({pb(2 * k + 1, id), pb(2 * k, id)});
		rd(TQHP_OFS_TX_DATA_POINTER);
		chk("pointer", 16'h4000 + 16'(4 + nw * 2), rdv);
		wr(TQHP_OFS_RX_QUEUE_COMMAND, 16'h0000);
		dw(16'hFFFF);
		rd(TQHP_OFS_TX_DATA_POINTER);
		chk("closed", 16'h4000 + 16'(4 + nw * 2), rdv);
		wr(TQHP_OFS_TX_QUEUE_COMMAND, 16'h0001);
		wr(TQHP_OFS_TX_QUEUE_COMMAND, 16'h0001);
		rd(TQHP_OFS_TX_FREE_MEMORY);
		chk("free", 16'h1800 - 16'(4 + nw * 2), rdv);
		k = 0;
		do
		begin
			rd(TQHP_OFS_TX_QUEUE_COMMAND);
			k++;
		end
		while (rdv[0] !== 1'b0 && k < 500);
		chk("enqueue", 16'h0000, {15'h0000, rdv[0]});
		chk("count", 16'(cnt), 16'(mac.n - n0));
		chk("last", 16'(cnt), 16'(mac.nl - n0));
		for (k = 0; k < cnt; k++)
			chk("byte", {8'h00, pb(k, id)}, {8'h00, mac.got[n0 + k]});
		rd(TQHP_OFS_TX_STATUS);
		chk("txst", {8'h00, slow, !slow, id}, {8'h00, rdv[13:12], rdv[5:0]});
		rd(TQHP_OFS_INT_STATUS);
		chk("txdone", {15'h0000, irq}, {15'h0000, rdv[14]});
		rd(TQHP_OFS_TX_FREE_MEMORY);
		chk("free", 16'h1800, rdv);
	endtask : t_frame
	task automatic t_clear();
		chk("irq_n", 16'h0000, {15'h0000, irq_n});
		wr(TQHP_OFS_INT_STATUS, 16'hFFFF);
		rd(TQHP_OFS_INT_STATUS);
		chk("status", 16'h0000, rdv);
		chk("irq_n", 16'h0001, {15'h0000, irq_n});
	endtask : t_clear
	task automatic t_space();
		wr(TQHP_OFS_TX_SPACE_REQUEST, 16'h0600);
		wr(TQHP_OFS_TX_QUEUE_COMMAND, 16'h0002);
		repeat (3) @(posedge clock);
		rd(TQHP_OFS_INT_STATUS);
		chk("space", 16'h0040, rdv);
		rd(TQHP_OFS_TX_QUEUE_COMMAND);
		chk("request", 16'h0000, {15'h0000, rdv[1]});
		wr(TQHP_OFS_INT_ENABLE, 16'h0040);
		@(posedge clock);
		#1;
		chk("irq_n", 16'h0000, {15'h0000, irq_n});
		wr(TQHP_OFS_INT_ENABLE, 16'h0000);
		@(posedge clock);
		#1;
		chk("irq_n", 16'h0001, {15'h0000, irq_n});
		wr(TQHP_OFS_INT_STATUS, 16'h0040);
		rd(TQHP_OFS_INT_STATUS);
		chk("status", 16'h0000, rdv);
		wr(TQHP_OFS_TX_SPACE_REQUEST, 16'h0601);
		wr(TQHP_OFS_TX_QUEUE_COMMAND, 16'h0002);
		repeat (6) @(posedge clock);
		rd(TQHP_OFS_INT_STATUS);
		chk("space", 16'h0000, rdv);
	endtask : t_space
	task automatic wrap_up();
		$display("checks %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	initial
	begin
		#80000;
		n_errors++;
		wrap_up();
	end
	initial
	begin
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_control();
		wr(TQHP_OFS_INT_ENABLE, 16'h4000);
		t_frame(6'h3F, 65, 1'b1, 1'b1);
		t_clear();
		t_frame(6'h05, 1, 1'b0, 1'b0);
		t_space();
		wrap_up();
	end
endmodule : test_transmit_queue_host_path
bind tqhp_top tqhp_checker chk_i (.clock(clock), .reset(reset), .host_addr(host_addr),
	.host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
	.data_wr(data_wr), .data_wdata(data_wdata), .mac_byte(mac_byte), .mac_valid(mac_valid),
	.mac_ready(mac_ready), .mac_done(mac_done), .mac_status(mac_status), .mac_cfg(mac_cfg),
	.irq_n(irq_n));
